// ---- src/ipw_pkg.sv ----
// Purpose: Constants and types for the indexed port watchdog
// Assumes: 25 MHz core clock
// Notes: Port addresses, indices, keys, field positions and tick counts
package ipw_pkg;

  // ****************************************
  // Ports, indices and keys
  // ****************************************
  localparam logic [15:0] IPW_INDEX_PORT = 16'h002E;
  localparam logic [15:0] IPW_DATA_PORT = 16'h002F;
  localparam logic [7:0] IPW_UNLOCK_KEY = 8'h87;
  localparam logic [7:0] IPW_LOCK_KEY = 8'hAA;
  localparam logic [7:0] IPW_IDX_FUNC_SEL = 8'h07;
  localparam logic [7:0] IPW_IDX_FUNC_EN = 8'h30;
  localparam logic [7:0] IPW_IDX_UNIT = 8'hF5;
  localparam logic [7:0] IPW_IDX_COUNT = 8'hF6;
  localparam logic [7:0] IPW_IDX_CTRL = 8'hF7;
  localparam logic [7:0] IPW_WDT_FUNC = 8'h08;
  localparam logic [7:0] IPW_FUNC_ON = 8'h01;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int IPW_UNIT_MIN_BIT = 3;
  localparam int IPW_MOUSE_BIT = 7;
  localparam int IPW_KBD_BIT = 6;
  localparam int IPW_FORCE_BIT = 5;
  localparam int IPW_STATUS_BIT = 4;
  localparam logic [7:0] IPW_COUNT_RST = 8'h00;
  localparam logic [7:0] IPW_INDEX_RST = 8'h00;
  localparam logic [7:0] IPW_FUNC_RST = 8'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam longint IPW_CLK_HZ = 25000000;
  localparam longint IPW_SEC_S = 1;
  localparam longint IPW_MIN_S = 60;
  localparam longint IPW_SEC_CYC = IPW_CLK_HZ * IPW_SEC_S;
  localparam int IPW_SEC_CYCLES = 25000000;
  localparam int IPW_MIN_SECONDS = 60;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    IPW_LOCKED = 2'b00,
    IPW_KEY_ONE = 2'b01,
    IPW_CONFIG = 2'b10
  } ipw_cfg_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] data;
  } ipw_io_s;

endpackage : ipw_pkg

// ---- src/ipw_watchdog.sv ----
// Purpose: Watchdog reached through an index/data I/O port pair
// Assumes: Host I/O cycles arrive as one-cycle strobes on the core clock
// Notes: Activity inputs are asynchronous and synchronised here
`timescale 1ns/1ps
`default_nettype none

module ipw_watchdog
  import ipw_pkg::*;
#(
  parameter int SEC_CYCLES = ipw_pkg::IPW_SEC_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire ipw_pkg::ipw_io_s i_io,
  input wire logic i_kbd_activity,
  input wire logic i_mouse_activity,
  output logic [7:0] o_rd_data,
  output logic o_timeout
);
  import ipw_pkg::*;

  ipw_cfg_e cfg_reg;
  logic [7:0] index_reg;
  logic [7:0] func_reg;
  logic enable_reg;
  logic unit_min_reg;
  logic [7:0] count_reg;
  logic [7:0] cnt_reg;
  logic mouse_en_reg;
  logic kbd_en_reg;
  logic status_reg;
  logic timeout_reg;
  logic [7:0] rd_reg;
  logic [24:0] pre_reg;
  logic [5:0] sec_reg;
  logic [2:0] kbd_sync_reg;
  logic [2:0] ms_sync_reg;
  logic kbd_last_reg;
  logic ms_last_reg;
  logic idx_wr;
  logic dat_wr;
  logic dat_rd;
  logic wdt_sel;
  logic count_wr;
  logic force_wr;
  logic tick;
  logic activity;
  logic expire;

  function automatic logic wdt_reg(input logic [7:0] idx);
    wdt_reg = (idx == IPW_IDX_UNIT) || (idx == IPW_IDX_COUNT) || (idx == IPW_IDX_CTRL);
  endfunction

  // ****************************************
  // Port decode
  // ****************************************
  assign idx_wr = i_clk_en && i_io.wr && (i_io.addr == IPW_INDEX_PORT);
  assign dat_wr = i_clk_en && i_io.wr && (i_io.addr == IPW_DATA_PORT) && (cfg_reg == IPW_CONFIG);
  assign dat_rd = i_clk_en && i_io.rd && (i_io.addr == IPW_DATA_PORT);
  assign wdt_sel = (func_reg == IPW_WDT_FUNC);
  assign count_wr = dat_wr && wdt_sel && (index_reg == IPW_IDX_COUNT);
  assign force_wr = dat_wr && wdt_sel && (index_reg == IPW_IDX_CTRL) && i_io.data[IPW_FORCE_BIT];

  // ****************************************
  // Configuration lock
  // ****************************************
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg_reg <= IPW_LOCKED;
    end else if (idx_wr) begin
      unique case (cfg_reg)
        IPW_LOCKED: cfg_reg <= (i_io.data == IPW_UNLOCK_KEY) ? IPW_KEY_ONE : IPW_LOCKED;
        IPW_KEY_ONE: cfg_reg <= (i_io.data == IPW_UNLOCK_KEY) ? IPW_CONFIG : IPW_LOCKED;
        IPW_CONFIG: cfg_reg <= (i_io.data == IPW_LOCK_KEY) ? IPW_LOCKED : IPW_CONFIG;
        default: cfg_reg <= IPW_LOCKED;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      index_reg <= IPW_INDEX_RST;
    end else if (idx_wr && cfg_reg == IPW_CONFIG && i_io.data != IPW_LOCK_KEY) begin
      index_reg <= i_io.data;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      func_reg <= IPW_FUNC_RST;
      enable_reg <= 1'b0;
      unit_min_reg <= 1'b0;
      count_reg <= IPW_COUNT_RST;
      mouse_en_reg <= 1'b0;
      kbd_en_reg <= 1'b0;
    end else if (dat_wr) begin
      if (index_reg == IPW_IDX_FUNC_SEL) begin
        func_reg <= i_io.data;
      end
      if (wdt_sel) begin
        if (index_reg == IPW_IDX_FUNC_EN) begin
          enable_reg <= (i_io.data == IPW_FUNC_ON);
        end
        if (index_reg == IPW_IDX_UNIT) begin
          unit_min_reg <= i_io.data[IPW_UNIT_MIN_BIT];
        end
        if (index_reg == IPW_IDX_COUNT) begin
          count_reg <= i_io.data;
        end
        if (index_reg == IPW_IDX_CTRL) begin
          mouse_en_reg <= i_io.data[IPW_MOUSE_BIT];
          kbd_en_reg <= i_io.data[IPW_KBD_BIT];
        end
      end
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_reg <= 8'h00;
    end else if (dat_rd) begin
      rd_reg <= 8'h00;
      if (cfg_reg == IPW_CONFIG) begin
        if (index_reg == IPW_IDX_FUNC_SEL) begin
          rd_reg <= func_reg;
        end else if (wdt_sel && index_reg == IPW_IDX_FUNC_EN) begin
          rd_reg <= {7'h00, enable_reg};
        end else if (wdt_sel && wdt_reg(index_reg)) begin
          unique case (index_reg)
            IPW_IDX_UNIT: rd_reg <= {4'h0, unit_min_reg, 3'h0};
            IPW_IDX_COUNT: rd_reg <= cnt_reg;
            default: rd_reg <= {mouse_en_reg, kbd_en_reg, 1'b0, status_reg, 4'h0};
          endcase
        end
      end
    end
  end
  assign o_rd_data = rd_reg;

  // ****************************************
  // Activity synchronisers
  // ****************************************
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      kbd_sync_reg <= 3'h0;
      ms_sync_reg <= 3'h0;
      kbd_last_reg <= 1'b0;
      ms_last_reg <= 1'b0;
    end else if (i_clk_en) begin
      kbd_sync_reg <= {kbd_sync_reg[1:0], i_kbd_activity};
      ms_sync_reg <= {ms_sync_reg[1:0], i_mouse_activity};
      if (kbd_sync_reg[1] == kbd_sync_reg[2]) begin
        kbd_last_reg <= kbd_sync_reg[2];
      end
      if (ms_sync_reg[1] == ms_sync_reg[2]) begin
        ms_last_reg <= ms_sync_reg[2];
      end
    end
  end
  assign activity = i_clk_en && (
    (kbd_en_reg && kbd_sync_reg[1] && kbd_sync_reg[2] && !kbd_last_reg) ||
    (mouse_en_reg && ms_sync_reg[1] && ms_sync_reg[2] && !ms_last_reg));

  // ****************************************
  // Prescaler
  // ****************************************
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pre_reg <= 25'h0000000;
      sec_reg <= 6'h00;
    end else if (i_clk_en) begin
      if (count_wr || activity) begin
        pre_reg <= 25'h0000000;
        sec_reg <= 6'h00;
      end else if (pre_reg == 25'(SEC_CYCLES - 1)) begin
        pre_reg <= 25'h0000000;
        sec_reg <= (tick || !unit_min_reg) ? 6'h00 : sec_reg + 6'h01;
      end else begin
        pre_reg <= pre_reg + 25'h0000001;
      end
    end
  end
  assign tick = (pre_reg == 25'(SEC_CYCLES - 1)) &&
    (!unit_min_reg || sec_reg == 6'(IPW_MIN_SECONDS - 1));

  // ****************************************
  // Counter and timeout
  // ****************************************
  assign expire = enable_reg && tick && (cnt_reg == 8'h01) && !count_wr && !activity;

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_reg <= IPW_COUNT_RST;
    end else if (i_clk_en) begin
      if (count_wr) begin
        cnt_reg <= i_io.data;
      end else if (activity) begin
        cnt_reg <= count_reg;
      end else if (enable_reg && tick && cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      status_reg <= 1'b0;
      timeout_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (expire || force_wr) begin
        status_reg <= 1'b1;
        timeout_reg <= 1'b1;
      end else if (count_wr) begin
        status_reg <= 1'b0;
        timeout_reg <= 1'b0;
      end
    end
  end
  assign o_timeout = timeout_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  locked_hold_a: assert property (cfg_reg != IPW_CONFIG |=> $stable(count_reg) && $stable(enable_reg))
    else $error("register changed while locked");
  unlock_seq_a: assert property (idx_wr && i_io.data == IPW_UNLOCK_KEY && cfg_reg == IPW_KEY_ONE |=> cfg_reg == IPW_CONFIG)
    else $error("double key did not unlock");
  lock_key_a: assert property (idx_wr && i_io.data == IPW_LOCK_KEY && cfg_reg == IPW_CONFIG |=> cfg_reg == IPW_LOCKED)
    else $error("lock key did not lock");
  count_load_a: assert property (count_wr |=> cnt_reg == $past(i_io.data) && pre_reg == 25'h0000000)
    else $error("count write did not reload");
  force_out_a: assert property (force_wr |=> o_timeout && status_reg)
    else $error("forced timeout missing");
  expire_out_a: assert property (expire |=> o_timeout && cnt_reg == 8'h00)
    else $error("expiry without timeout");
  zero_stop_a: assert property (cnt_reg == 8'h00 && !count_wr && !activity |=> cnt_reg == 8'h00)
    else $error("zero count moved");
  disabled_hold_a: assert property (!enable_reg && !count_wr && !activity |=> $stable(cnt_reg))
    else $error("counter ran while disabled");
  status_rd_a: assert property (dat_rd && cfg_reg == IPW_CONFIG && wdt_sel && index_reg == IPW_IDX_CTRL |=> o_rd_data[IPW_STATUS_BIT] == $past(status_reg))
    else $error("status bit misread");

  unlock_c: cover property (cfg_reg == IPW_KEY_ONE ##1 cfg_reg == IPW_CONFIG);
  expire_c: cover property (expire);
  force_c: cover property (force_wr);
  activity_c: cover property (activity);

endmodule // ipw_watchdog

`default_nettype wire

// ---- testbench/ipw_host_model.sv ----
// Purpose: Host processor model issuing I/O port cycles
// Assumes: One-cycle strobes launched 1 ns after the rising edge
// Notes: Address and data show inverted values while idle
`timescale 1ns/1ps
`default_nettype none
module ipw_host_model (
  input wire logic i_core_clk,
  input wire logic [7:0] i_rd_data,
  output var ipw_pkg::ipw_io_s o_io
);
  import ipw_pkg::*;

  initial o_io = '{wr: 1'b0, rd: 1'b0, addr: 16'h0000, data: 8'h00};

  task automatic cycle(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    #1;
    o_io = '{wr: w, rd: !w, addr: a, data: d};
    @(posedge i_core_clk);
    #1;
    o_io = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cycle(1'b1, a, d);
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    cycle(1'b0, a, 8'h00);
    @(posedge i_core_clk);
    #1;
    d = i_rd_data;
  endtask

  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    wr(IPW_INDEX_PORT, idx);
    wr(IPW_DATA_PORT, d);
  endtask

  task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d);
    wr(IPW_INDEX_PORT, idx);
    rd(IPW_DATA_PORT, d);
  endtask

  task automatic open_cfg();
    wr(IPW_INDEX_PORT, IPW_UNLOCK_KEY);
    wr(IPW_INDEX_PORT, IPW_UNLOCK_KEY);
    reg_wr(IPW_IDX_FUNC_SEL, IPW_WDT_FUNC);
  endtask

  task automatic close_cfg();
    wr(IPW_INDEX_PORT, IPW_LOCK_KEY);
  endtask
endmodule // ipw_host_model
`default_nettype wire

// ---- testbench/indexed_port_watchdog_timer_test.sv ----
// Purpose: Self-checking bench for the indexed port watchdog
// Assumes: A second shortened to SC core cycles
// Notes: Host cycles come from the partner model
`timescale 1ns/1ps
`default_nettype none
module indexed_port_watchdog_timer_test;
  import ipw_pkg::*;
  localparam int SC = 10;
  logic core_clk;
  logic sys_rst;
  logic kbd;
  logic mouse;
  logic clk_en;
  ipw_io_s io;
  logic [7:0] rd_data;
  logic timeout;
  int n_mismatch = 0;
  int samples_checked = 0;
  integer seed = 17429;
  logic [7:0] v;
  logic [7:0] c;

  ipw_watchdog #(.SEC_CYCLES(SC)) dut_u (.i_core_clk(core_clk), .i_sys_rst(sys_rst),
    .i_clk_en(clk_en), .i_io(io), .i_kbd_activity(kbd), .i_mouse_activity(mouse),
    .o_rd_data(rd_data), .o_timeout(timeout));
  ipw_host_model host_u (.i_core_clk(core_clk), .i_rd_data(rd_data), .o_io(io));

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    check_byte({7'h00, got}, {7'h00, exp});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  function automatic int ticks_to_cycles(input logic [7:0] cnt, input logic minute);
    return int'(cnt) * SC * (minute ? IPW_MIN_SECONDS : 1);
  endfunction

  // Load a count and expect expiry within a few cycles of its length
  task automatic run_timeout(input logic [7:0] cnt, input logic minute);
    int cyc;
    cyc = ticks_to_cycles(cnt, minute);
    host_u.reg_wr(IPW_IDX_COUNT, cnt);
    wait_cyc(cyc - 3);
    check_flag(timeout, 1'b0);
    wait_cyc(6);
    check_flag(timeout, 1'b1);
    host_u.reg_rd(IPW_IDX_CTRL, v);
    check_byte(v & 8'h10, 8'h10);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    #(20000 * 40);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    sys_rst = 1'b1;
    kbd = 1'b0;
    mouse = 1'b0;
    clk_en = 1'b1;
    wait_cyc(20);
    sys_rst = 1'b0;
    host_u.rd(IPW_DATA_PORT, v);
    check_byte(v, 8'h00);
    host_u.open_cfg();
    host_u.reg_rd(IPW_IDX_FUNC_SEL, v);
    check_byte(v, IPW_WDT_FUNC);
    host_u.reg_rd(IPW_IDX_CTRL, v);
    check_byte(v, 8'h00);
    host_u.reg_wr(IPW_IDX_COUNT, 8'h01);
    wait_cyc(3 * SC);
    check_flag(timeout, 1'b0);
    host_u.reg_wr(IPW_IDX_FUNC_EN, IPW_FUNC_ON);
    host_u.reg_rd(IPW_IDX_FUNC_EN, v);
    check_byte(v, 8'h01);
    end_test("defaults");
    repeat (4) run_timeout(8'(1 + ($random(seed) & 3)), 1'b0);
    host_u.reg_wr(IPW_IDX_UNIT, 8'h08);
    host_u.reg_rd(IPW_IDX_UNIT, v);
    check_byte(v, 8'h08);
    run_timeout(8'h01, 1'b1);
    host_u.reg_wr(IPW_IDX_UNIT, 8'h00);
    end_test("timeout");
    for (int i = 0; i < 3; i++) begin
      c = (i == 0) ? 8'h00 : ((i == 1) ? 8'h40 : 8'h80);
      host_u.reg_wr(IPW_IDX_CTRL, c);
      host_u.reg_wr(IPW_IDX_COUNT, 8'h03);
      wait_cyc(14);
      kbd = (i < 2);
      mouse = (i == 2);
      wait_cyc(4);
      kbd = 1'b0;
      mouse = 1'b0;
      wait_cyc(18);
      check_flag(timeout, i == 0);
      wait_cyc(18);
      check_flag(timeout, 1'b1);
      host_u.reg_rd(IPW_IDX_CTRL, v);
      check_byte(v, c | 8'h10);
    end
    end_test("activity");
    host_u.reg_wr(IPW_IDX_CTRL, 8'h00);
    host_u.reg_wr(IPW_IDX_COUNT, 8'h00);
    wait_cyc(3 * SC);
    check_flag(timeout, 1'b0);
    host_u.reg_wr(IPW_IDX_CTRL, 8'h20);
    wait_cyc(1);
    check_flag(timeout, 1'b1);
    host_u.reg_rd(IPW_IDX_CTRL, v);
    check_byte(v, 8'h10);
    end_test("force");
    host_u.reg_wr(IPW_IDX_COUNT, 8'h01);
    wait_cyc(2);
    clk_en = 1'b0;
    host_u.wr(IPW_DATA_PORT, 8'h00);
    wait_cyc(3 * SC);
    check_flag(timeout, 1'b0);
    clk_en = 1'b1;
    wait_cyc(SC + 2);
    check_flag(timeout, 1'b1);
    host_u.reg_wr(IPW_IDX_FUNC_SEL, 8'h00);
    host_u.reg_wr(IPW_IDX_COUNT, 8'h01);
    check_flag(timeout, 1'b1);
    host_u.reg_wr(IPW_IDX_FUNC_SEL, IPW_WDT_FUNC);
    end_test("freeze");
    host_u.reg_wr(IPW_IDX_COUNT, 8'h00);
    host_u.close_cfg();
    host_u.wr(IPW_DATA_PORT, 8'h01);
    host_u.wr(IPW_INDEX_PORT, IPW_UNLOCK_KEY);
    host_u.wr(IPW_DATA_PORT, 8'h01);
    wait_cyc(3 * SC);
    check_flag(timeout, 1'b0);
    host_u.rd(IPW_DATA_PORT, v);
    check_byte(v, 8'h00);
    end_test("lock");
    print_verdict();
  end
endmodule // indexed_port_watchdog_timer_test
`default_nettype wire
